// [hw/fra_pkg.sv]
/*
 * fra_pkg: shared constants for the floating-point register access block.
 * Assumes a single 200 MHz core clock and an AXI4-Lite register bus with 32-bit data.
 */
package fra_pkg;
   localparam int unsigned FRA_NUM_FPR    = 32;
   localparam int unsigned FRA_BANK_DEPTH = 16;
   localparam int unsigned FRA_FPR_W      = 64;
   localparam int unsigned FRA_ADDR_W     = 8;
   localparam int unsigned FRA_RD_LATENCY = 2;

   // operand formats presented by the pipeline
   localparam logic [2:0] FRA_FMT_S  = 3'h0;
   localparam logic [2:0] FRA_FMT_W  = 3'h1;
   localparam logic [2:0] FRA_FMT_UW = 3'h2;
   localparam logic [2:0] FRA_FMT_D  = 3'h3;
   localparam logic [2:0] FRA_FMT_UD = 3'h4;
   localparam logic [2:0] FRA_FMT_L  = 3'h5;
   localparam logic [2:0] FRA_FMT_PS = 3'h6;

   // control/status register fields
   localparam int unsigned FRA_UNIMPL_BIT   = 17;
   localparam int unsigned FRA_CAUSE_LO     = 12;
   localparam int unsigned FRA_ENABLE_LO    = 7;
   localparam int unsigned FRA_CAUSE_W      = 5;
   localparam logic [4:0]  FRA_CC0_BIT      = 5'h17;
   localparam logic [4:0]  FRA_CCN_BASE     = 5'h18;
   localparam logic [31:0] FRA_FP_CONTROL_STATUS_REGISTER_RESET   = 32'h0000_0000;

   // register map (byte addresses)
   localparam logic [7:0] FRA_OFS_CTRL   = 8'h00;
   localparam logic [7:0] FRA_OFS_FP_CONTROL_STATUS_REGISTER   = 8'h04;
   localparam logic [7:0] FRA_OFS_STATUS = 8'h08;
   localparam int unsigned FRA_CTRL_NARROW_BIT = 0;
   localparam int unsigned FRA_STAT_DEBUG_BIT  = 0;
   localparam int unsigned FRA_STAT_EXC_BIT    = 1;
   localparam logic        FRA_NARROW_RESET    = 1'b1;

   localparam logic [1:0] FRA_RESP_OKAY   = 2'h0;
   localparam logic [1:0] FRA_RESP_SLVERR = 2'h2;
endpackage

// [hw/fra_bank.sv]
/*
 * fra_bank: one bank of floating-point registers, one write and one registered read port.
 * Assumes synchronous active-low reset; read returns the old word on a same-cycle write.
 */
`timescale 1ns/100ps
module fra_bank
   import fra_pkg::*;
(
   input  wire logic                      i_clk,
   input  wire logic                      i_reset_n,
   input  wire logic                      i_we,
   input  wire logic [3:0]                i_waddr,
   input  wire logic [FRA_FPR_W-1:0]      i_wdata,
   input  wire logic [3:0]                i_raddr,
   output logic      [FRA_FPR_W-1:0]      o_rdata
);
   logic [FRA_FPR_W-1:0] mem [FRA_BANK_DEPTH];
   logic [FRA_FPR_W-1:0] next_rdata;

   always_comb begin
      next_rdata = mem[i_raddr];
   end

   // storage itself has no reset so it can map onto ram cells
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= next_rdata;
      end
   end
endmodule

// [hw/fra_top.sv]
/*
 * fra_top: floating-point register access, condition codes, exception and nullify signalling.
 * Assumes the pipeline presents one instruction's requests per cycle and an AXI4-Lite master.
 */
// What this block does
// - narrow doubleword read pairs odd above even
// - narrow doubleword write splits into even, odd
// - long/paired narrow unpredictable, else whole register
// - raise exception on unimplemented or enabled cause
// - condition code 0 bit 23, else 24+n
// - condition code write changes only its bit
// - exception aborts instruction, no remaining effect
// - breakpoint outside debug aborts, enters debug
// - breakpoint inside debug gives debug-mode breakpoint
// - nullify kills effect, exceptions, likely delay slot
`timescale 1ns/100ps
module fra_top
   import fra_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_reset_n,
   input  wire logic                  i_s_axi_awvalid,
   output logic                       o_s_axi_awready,
   input  wire logic [FRA_ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic                  i_s_axi_wvalid,
   output logic                       o_s_axi_wready,
   input  wire logic [31:0]           i_s_axi_wdata,
   input  wire logic [3:0]            i_s_axi_wstrb,
   output logic                       o_s_axi_bvalid,
   input  wire logic                  i_s_axi_bready,
   output logic      [1:0]            o_s_axi_bresp,
   input  wire logic                  i_s_axi_arvalid,
   output logic                       o_s_axi_arready,
   input  wire logic [FRA_ADDR_W-1:0] i_s_axi_araddr,
   output logic                       o_s_axi_rvalid,
   input  wire logic                  i_s_axi_rready,
   output logic      [31:0]           o_s_axi_rdata,
   output logic      [1:0]            o_s_axi_rresp,
   input  wire logic                  i_rd_valid,
   input  wire logic [4:0]            i_rd_reg,
   input  wire logic [2:0]            i_rd_fmt,
   output logic                       o_rd_valid,
   output logic      [63:0]           o_rd_data,
   input  wire logic                  i_wr_valid,
   input  wire logic [4:0]            i_wr_reg,
   input  wire logic [2:0]            i_wr_fmt,
   input  wire logic [63:0]           i_wr_data,
   input  wire logic [2:0]            i_cc_sel,
   output logic                       o_cc_value,
   input  wire logic                  i_cc_wr_valid,
   input  wire logic                  i_cc_wr_value,
   input  wire logic                  i_check_valid,
   input  wire logic                  i_signal_exc,
   input  wire logic [31:0]           i_exc_arg,
   input  wire logic                  i_debug_break,
   input  wire logic                  i_nullify,
   input  wire logic                  i_branch_likely,
   output logic                       o_abort,
   output logic                       o_fp_exception,
   output logic                       o_exc_signalled,
   output logic      [31:0]           o_exc_arg,
   output logic                       o_debug_entry,
   output logic                       o_debug_mode_break,
   output logic                       o_debug_mode,
   output logic                       o_nullified,
   output logic                       o_kill_delay_slot,
   output logic                       o_narrow_mode
);
   function automatic logic [4:0] cc_bit_index(input logic [2:0] cc);
      cc_bit_index = (cc == 3'h0) ? FRA_CC0_BIT : FRA_CCN_BASE + {2'h0, cc};
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      strb_merge = r;
   endfunction

   function automatic logic exc_enabled(input logic [31:0] f);
      exc_enabled = f[FRA_UNIMPL_BIT] ||
                    ((f[FRA_CAUSE_LO +: FRA_CAUSE_W] & f[FRA_ENABLE_LO +: FRA_CAUSE_W]) != '0);
   endfunction

   // register bus state
   logic [FRA_ADDR_W-1:0] aw_addr;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  next_awready;
   logic                  next_wready;
   logic                  next_bvalid;
   logic [1:0]            next_bresp;
   logic                  next_arready;
   logic                  next_rvalid;
   logic [31:0]           next_rdata;
   logic [1:0]            next_rresp;
   logic [FRA_ADDR_W-1:0] next_aw_addr;
   logic [31:0]           next_w_data;
   logic [3:0]            next_w_strb;
   logic                  wr_go;

   // architectural state
   logic [31:0] fp_control_status_register;
   logic [31:0] next_fp_control_status_register;
   logic        narrow;
   logic        next_narrow;
   logic        debug_mode;
   logic        next_debug_mode;
   logic        exc_pending;

   // pipeline state and outputs
   logic        next_abort;
   logic        next_fp_exc;
   logic        next_exc_sig;
   logic [31:0] next_exc_arg;
   logic        next_dbg_entry;
   logic        next_dbg_mode_break;
   logic        next_nullified;
   logic        next_kill_ds;
   logic        next_cc_value;
   logic        rd_p1;
   logic        rd_odd_p1;
   logic [2:0]  rd_fmt_p1;
   logic        rd_narrow_p1;
   logic [63:0] next_rd_data;
   logic        exc_any;
   logic        commit;

   // bank ports
   logic        ev_we;
   logic        od_we;
   logic [3:0]  ev_waddr;
   logic [3:0]  od_waddr;
   logic [63:0] ev_wdata;
   logic [63:0] od_wdata;
   logic [63:0] ev_q;
   logic [63:0] od_q;
   logic [63:0] sel_q;

   fra_bank u_even (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_we      (ev_we),
      .i_waddr   (ev_waddr),
      .i_wdata   (ev_wdata),
      .i_raddr   (i_rd_reg[4:1]),
      .o_rdata   (ev_q)
   );

   fra_bank u_odd (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_we      (od_we),
      .i_waddr   (od_waddr),
      .i_wdata   (od_wdata),
      .i_raddr   (i_rd_reg[4:1]),
      .o_rdata   (od_q)
   );

   assign exc_pending = exc_enabled(fp_control_status_register);

   // exception and nullify decision for the current instruction
   always_comb begin
      exc_any = !i_nullify && (i_debug_break || i_signal_exc ||
                               (i_check_valid && exc_enabled(fp_control_status_register)));
      commit  = !i_nullify && !exc_any;
   end

   // register bus slave plus architectural state
   always_comb begin
      next_awready    = o_s_axi_awready;
      next_wready     = o_s_axi_wready;
      next_bvalid     = o_s_axi_bvalid;
      next_bresp      = o_s_axi_bresp;
      next_arready    = o_s_axi_arready;
      next_rvalid     = o_s_axi_rvalid;
      next_rdata      = o_s_axi_rdata;
      next_rresp      = o_s_axi_rresp;
      next_aw_addr    = aw_addr;
      next_w_data     = w_data;
      next_w_strb     = w_strb;
      next_fp_control_status_register       = fp_control_status_register;
      next_narrow     = narrow;
      next_debug_mode = debug_mode;
      wr_go           = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
      if (i_s_axi_awvalid && o_s_axi_awready) begin
         next_awready = 1'b0;
         next_aw_addr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
         next_wready = 1'b0;
         next_w_data = i_s_axi_wdata;
         next_w_strb = i_s_axi_wstrb;
      end
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp  = FRA_RESP_OKAY;
         if (aw_addr == FRA_OFS_CTRL) begin
            // mode bit sits in byte 0, so only that strobe matters
            next_narrow = w_strb[0] ? w_data[FRA_CTRL_NARROW_BIT] : narrow;
         end else if (aw_addr == FRA_OFS_FP_CONTROL_STATUS_REGISTER) begin
            next_fp_control_status_register = strb_merge(fp_control_status_register, w_data, w_strb);
         end else if (aw_addr == FRA_OFS_STATUS) begin
            if (w_strb[0] && w_data[FRA_STAT_DEBUG_BIT]) begin
               next_debug_mode = 1'b0;
            end
         end else begin
            next_bresp = FRA_RESP_SLVERR;
         end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
         next_bvalid  = 1'b0;
         next_awready = 1'b1;
         next_wready  = 1'b1;
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = FRA_RESP_OKAY;
         if (i_s_axi_araddr == FRA_OFS_CTRL) begin
            next_rdata = {31'h0, narrow};
         end else if (i_s_axi_araddr == FRA_OFS_FP_CONTROL_STATUS_REGISTER) begin
            next_rdata = fp_control_status_register;
         end else if (i_s_axi_araddr == FRA_OFS_STATUS) begin
            next_rdata = {30'h0, exc_pending, debug_mode};
         end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = FRA_RESP_SLVERR;
         end
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      // pipeline condition-code write lands after the bus write, so hardware wins
      if (i_cc_wr_valid && commit) begin
         next_fp_control_status_register[cc_bit_index(i_cc_sel)] = i_cc_wr_value;
      end
      // entering debug sets the flag even if software clears it this cycle
      if (i_debug_break && !i_nullify && !debug_mode) begin
         next_debug_mode = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready  <= 1'b1;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= FRA_RESP_OKAY;
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0000_0000;
         o_s_axi_rresp   <= FRA_RESP_OKAY;
         aw_addr         <= '0;
         w_data          <= 32'h0000_0000;
         w_strb          <= 4'h0;
         fp_control_status_register            <= FRA_FP_CONTROL_STATUS_REGISTER_RESET;
         narrow          <= FRA_NARROW_RESET;
         debug_mode      <= 1'b0;
      end else begin
         o_s_axi_awready <= next_awready;
         o_s_axi_wready  <= next_wready;
         o_s_axi_bvalid  <= next_bvalid;
         o_s_axi_bresp   <= next_bresp;
         o_s_axi_arready <= next_arready;
         o_s_axi_rvalid  <= next_rvalid;
         o_s_axi_rdata   <= next_rdata;
         o_s_axi_rresp   <= next_rresp;
         aw_addr         <= next_aw_addr;
         w_data          <= next_w_data;
         w_strb          <= next_w_strb;
         fp_control_status_register            <= next_fp_control_status_register;
         narrow          <= next_narrow;
         debug_mode      <= next_debug_mode;
      end
   end

   // register writes steered by format and mode
   always_comb begin
      ev_we    = 1'b0;
      od_we    = 1'b0;
      ev_waddr = i_wr_reg[4:1];
      od_waddr = i_wr_reg[4:1];
      // narrow mode keeps upper halves zero so nothing stale leaks back out
      ev_wdata = narrow ? {32'h0, i_wr_data[31:0]} : i_wr_data;
      od_wdata = ev_wdata;
      if (i_wr_valid && commit) begin
         if (i_wr_fmt == FRA_FMT_S || i_wr_fmt == FRA_FMT_W || i_wr_fmt == FRA_FMT_UW) begin
            ev_we = !i_wr_reg[0];
            od_we = i_wr_reg[0];
         end else if (i_wr_fmt == FRA_FMT_D || i_wr_fmt == FRA_FMT_UD) begin
            if (narrow) begin
               ev_we    = !i_wr_reg[0];
               od_we    = !i_wr_reg[0];
               od_wdata = {32'h0, i_wr_data[63:32]};
            end else begin
               ev_we = !i_wr_reg[0];
               od_we = i_wr_reg[0];
            end
         end else if (i_wr_fmt == FRA_FMT_L || i_wr_fmt == FRA_FMT_PS) begin
            ev_we = !narrow && !i_wr_reg[0];
            od_we = !narrow && i_wr_reg[0];
         end
      end
   end

   // read data selection and instruction outcome
   always_comb begin
      sel_q        = rd_odd_p1 ? od_q : ev_q;
      next_rd_data = 64'h0;
      if (rd_fmt_p1 == FRA_FMT_S || rd_fmt_p1 == FRA_FMT_W || rd_fmt_p1 == FRA_FMT_UW) begin
         next_rd_data = sel_q;
      end else if (rd_fmt_p1 == FRA_FMT_D || rd_fmt_p1 == FRA_FMT_UD) begin
         if (!rd_narrow_p1) begin
            next_rd_data = sel_q;
         end else if (!rd_odd_p1) begin
            next_rd_data = {od_q[31:0], ev_q[31:0]};
         end
      end else if (rd_fmt_p1 == FRA_FMT_L || rd_fmt_p1 == FRA_FMT_PS) begin
         next_rd_data = rd_narrow_p1 ? 64'h0 : sel_q;
      end
      next_cc_value       = fp_control_status_register[cc_bit_index(i_cc_sel)];
      next_abort          = exc_any;
      next_dbg_entry      = exc_any && i_debug_break && !debug_mode;
      next_dbg_mode_break = exc_any && i_debug_break && debug_mode;
      next_exc_sig        = exc_any && !i_debug_break && i_signal_exc;
      next_fp_exc         = exc_any && !i_debug_break && !i_signal_exc;
      next_exc_arg        = next_exc_sig ? i_exc_arg : 32'h0000_0000;
      next_nullified      = i_nullify;
      next_kill_ds        = i_nullify && i_branch_likely;
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rd_p1              <= 1'b0;
         rd_odd_p1          <= 1'b0;
         rd_fmt_p1          <= FRA_FMT_S;
         rd_narrow_p1       <= 1'b0;
         o_rd_valid         <= 1'b0;
         o_rd_data          <= 64'h0;
         o_cc_value         <= 1'b0;
         o_abort            <= 1'b0;
         o_fp_exception     <= 1'b0;
         o_exc_signalled    <= 1'b0;
         o_exc_arg          <= 32'h0000_0000;
         o_debug_entry      <= 1'b0;
         o_debug_mode_break <= 1'b0;
         o_nullified        <= 1'b0;
         o_kill_delay_slot  <= 1'b0;
         o_debug_mode       <= 1'b0;
         o_narrow_mode      <= FRA_NARROW_RESET;
      end else begin
         rd_p1              <= i_rd_valid;
         rd_odd_p1          <= i_rd_reg[0];
         rd_fmt_p1          <= i_rd_fmt;
         rd_narrow_p1       <= narrow;
         o_rd_valid         <= rd_p1;
         o_rd_data          <= rd_p1 ? next_rd_data : 64'h0;
         o_cc_value         <= next_cc_value;
         o_abort            <= next_abort;
         o_fp_exception     <= next_fp_exc;
         o_exc_signalled    <= next_exc_sig;
         o_exc_arg          <= next_exc_arg;
         o_debug_entry      <= next_dbg_entry;
         o_debug_mode_break <= next_dbg_mode_break;
         o_nullified        <= next_nullified;
         o_kill_delay_slot  <= next_kill_ds;
         o_debug_mode       <= next_debug_mode;
         o_narrow_mode      <= next_narrow;
      end
   end

   sequence s_narrow_d_read(logic odd);
      i_rd_valid && narrow && i_rd_reg[0] == odd &&
      (i_rd_fmt == FRA_FMT_D || i_rd_fmt == FRA_FMT_UD);
   endsequence
   sequence s_read_answer;
      ##1 rd_p1 ##1 o_rd_valid;
   endsequence

   property p_pair_read;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_narrow_d_read(1'b0) |-> s_read_answer ##0
         (o_rd_data == {$past(od_q[31:0]), $past(ev_q[31:0])});
   endproperty
   a_pair_read: assert property (p_pair_read) else $error("paired read wrong");

   property p_odd_read_zero;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_narrow_d_read(1'b1) |-> s_read_answer ##0 (o_rd_data == 64'h0);
   endproperty
   a_odd_read_zero: assert property (p_odd_read_zero) else $error("odd read leaks data");

   property p_pair_write;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_valid && commit && narrow && !i_wr_reg[0] && i_wr_fmt == FRA_FMT_D) |->
         ev_we && od_we && ev_wdata[63:32] == 32'h0 && od_wdata[31:0] == i_wr_data[63:32];
   endproperty
   a_pair_write: assert property (p_pair_write) else $error("paired write wrong");

   property p_narrow_long_read;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd_valid && narrow && (i_rd_fmt == FRA_FMT_L || i_rd_fmt == FRA_FMT_PS)) |->
         ##2 (o_rd_valid && o_rd_data == 64'h0);
   endproperty
   a_narrow_long_read: assert property (p_narrow_long_read) else $error("long read");

   property p_wide_single_write;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_valid && commit && !narrow) |-> !(ev_we && od_we);
   endproperty
   a_wide_single_write: assert property (p_wide_single_write) else $error("pairing wide");

   property p_fp_exception;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_check_valid && exc_enabled(fp_control_status_register) && !i_nullify && !i_debug_break && !i_signal_exc)
         |=> o_fp_exception && o_abort;
   endproperty
   a_fp_exception: assert property (p_fp_exception) else $error("missed fp exception");

   property p_cc_read;
      @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> o_cc_value == $past(fp_control_status_register[cc_bit_index(i_cc_sel)]);
   endproperty
   a_cc_read: assert property (p_cc_read) else $error("wrong condition code bit");

   property p_cc_write;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_cc_wr_valid && commit && !(wr_go && aw_addr == FRA_OFS_FP_CONTROL_STATUS_REGISTER)) |=>
         (fp_control_status_register ^ $past(fp_control_status_register)) == (($past(fp_control_status_register[cc_bit_index(i_cc_sel)]) ^
          $past(i_cc_wr_value)) ? (32'h1 << $past(cc_bit_index(i_cc_sel))) : 32'h0);
   endproperty
   a_cc_write: assert property (p_cc_write) else $error("cc write hit other bits");

   property p_abort_no_effect;
      @(posedge i_clk) disable iff (!i_reset_n)
      exc_any |-> !ev_we && !od_we ##1 o_abort;
   endproperty
   a_abort_no_effect: assert property (p_abort_no_effect) else $error("aborted op wrote");

   property p_debug_entry;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_debug_break && !i_nullify && !debug_mode) |=> o_debug_entry && debug_mode && o_abort;
   endproperty
   a_debug_entry: assert property (p_debug_entry) else $error("no debug entry");

   property p_debug_mode_break;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_debug_break && !i_nullify && debug_mode) |=>
         o_debug_mode_break && !o_debug_entry && o_abort;
   endproperty
   a_debug_mode_break: assert property (p_debug_mode_break) else $error("no dbg-mode bp");

   property p_nullify;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_nullify |-> !ev_we && !od_we ##1 !o_abort && o_nullified &&
         o_kill_delay_slot == $past(i_branch_likely);
   endproperty
   a_nullify: assert property (p_nullify) else $error("nullify not honoured");
endmodule

// [verification/fra_pipe_model.sv]
/* fra_pipe_model: pipeline side, issues register, cc and event requests.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/100ps
module fra_pipe_model (
   input  wire logic   i_clk,
   output logic        i_rd_valid, i_wr_valid, i_cc_wr_valid, i_cc_wr_value, i_check_valid,
   output logic        i_signal_exc, i_debug_break, i_nullify, i_branch_likely,
   output logic [4:0]  i_rd_reg, i_wr_reg,
   output logic [2:0]  i_rd_fmt, i_wr_fmt, i_cc_sel,
   output logic [63:0] i_wr_data,
   output logic [31:0] i_exc_arg
);
   initial begin
      {i_rd_valid, i_wr_valid, i_cc_wr_valid, i_cc_wr_value, i_check_valid} = '0;
      {i_signal_exc, i_debug_break, i_nullify, i_branch_likely} = '0;
      {i_rd_reg, i_wr_reg, i_rd_fmt, i_wr_fmt, i_cc_sel, i_wr_data} = '0;
      i_exc_arg = 32'h0000_5a5a;
   end
   // reads a register in the format given, whatever format it was last written with
   task rd(input logic [4:0] r, input logic [2:0] f);
      @(posedge i_clk);
      {i_rd_valid, i_rd_reg, i_rd_fmt} <= {1'h1, r, f};
      @(posedge i_clk) i_rd_valid <= 1'h0;
   endtask
   task wr(input logic [4:0] r, input logic [2:0] f, input logic [63:0] d, input logic n);
      @(posedge i_clk);
      {i_wr_valid, i_wr_reg, i_wr_fmt, i_wr_data, i_nullify} <= {1'h1, r, f, d, n};
      @(posedge i_clk) {i_wr_valid, i_nullify} <= 2'h0;
   endtask
   // e: branch likely, cc write, cc value, check, signal, break, nullify
   task ev(input logic [2:0] s, input logic [6:0] e);
      @(posedge i_clk);
      i_cc_sel <= s;
      {i_branch_likely, i_cc_wr_valid, i_cc_wr_value, i_check_valid, i_signal_exc,
       i_debug_break, i_nullify} <= e;
      @(posedge i_clk);
      {i_branch_likely, i_cc_wr_valid, i_cc_wr_value, i_check_valid, i_signal_exc,
       i_debug_break, i_nullify} <= '0;
   endtask
endmodule

// [verification/testbench.sv]
/* testbench: register bus and pipeline sequences with expected values.
   assumes design outputs update by non-blocking assignment. */
`timescale 1ns/100ps
module testbench;
   import fra_pkg::*;
   logic i_clk = 0, i_reset_n = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
   logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, o_s_axi_awready, o_s_axi_wready;
   logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
   logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata, o_exc_arg, i_exc_arg;
   logic [3:0] i_s_axi_wstrb = 4'hf;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic [63:0] o_rd_data, i_wr_data;
   logic [4:0] i_rd_reg, i_wr_reg, ex = 5'h0d;
   logic [2:0] i_rd_fmt, i_wr_fmt, i_cc_sel;
   logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_rd_valid, o_cc_value, o_abort;
   logic o_fp_exception, o_exc_signalled, o_debug_entry, o_debug_mode_break, o_debug_mode;
   logic o_nullified, o_kill_delay_slot, o_narrow_mode, i_rd_valid, i_wr_valid, i_nullify;
   logic i_cc_wr_valid, i_cc_wr_value, i_check_valid, i_signal_exc, i_debug_break, i_branch_likely;
   logic [31:0] fc [5] = '{32'h1080, 32'h1000, 32'h2_0000, 32'h1_0800, 32'h1_0080};
   int num_errors = 0, check_count = 0, cycles = 0;
   fra_top fra_top_i (.*);
   fra_pipe_model fra_pipe_model_i (.*);
   initial forever #2.5 i_clk = ~i_clk;
   task chk(input string n, input logic [64:0] s, input logic [64:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task finish_test;
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(posedge i_clk);
         if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
      end while (!o_s_axi_bvalid);
      i_s_axi_bready <= 1'h0;
      chk("bresp", o_s_axi_bresp, FRA_RESP_OKAY);
   endtask
   task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge i_clk);
      {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge i_clk);
         if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
      end while (!o_s_axi_rvalid);
      i_s_axi_rready <= 1'h0;
      chk("rresp_rdata", {o_s_axi_rresp, o_s_axi_rdata}, {r, e});
   endtask
   task prd(input logic [4:0] r, input logic [2:0] f, input logic [63:0] e);
      fra_pipe_model_i.rd(r, f);
      @(posedge i_clk);
      #1 chk("rd", {o_rd_valid, o_rd_data}, {1'h1, e});
   endtask
   task pev(input logic [2:0] s, input logic [5:0] e, input logic [6:0] x);
      fra_pipe_model_i.ev(s, e);
      #1 chk("events", {o_abort, o_fp_exception, o_exc_signalled, o_debug_entry,
                         o_debug_mode_break, o_nullified, o_debug_mode}, x);
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'h1;
      chk("narrow", o_narrow_mode, 1'h1);
      fra_pipe_model_i.wr(5'h2, FRA_FMT_D, 64'h1122_3344_5566_7788, 1'h0);
      prd(5'h2, FRA_FMT_D, 64'h1122_3344_5566_7788);
      prd(5'h3, FRA_FMT_S, 64'h1122_3344);
      prd(5'h3, FRA_FMT_D, 64'h0);
      prd(5'h2, FRA_FMT_L, 64'h0);
      axw(FRA_OFS_CTRL, 32'h0);
      chk("narrow", o_narrow_mode, 1'h0);
      fra_pipe_model_i.wr(5'h5, FRA_FMT_L, 64'hdead_beef_0bad_f00d, 1'h0);
      prd(5'h5, FRA_FMT_L, 64'hdead_beef_0bad_f00d);
      fra_pipe_model_i.wr(5'h5, FRA_FMT_L, 64'h1, 1'h1);
      #1 chk("nullified", {o_nullified, o_kill_delay_slot}, 2'h2);
      prd(5'h5, FRA_FMT_L, 64'hdead_beef_0bad_f00d);
      for (int n = 0; n < 8; n += 3) begin
         pev(3'(n), 6'h30, 7'h0);
         @(posedge i_clk);
         #1 chk("cc", o_cc_value, 1'h1);
      end
      axr(FRA_OFS_FP_CONTROL_STATUS_REGISTER, 32'h4880_0000, FRA_RESP_OKAY);
      for (int k = 0; k < 5; k++) begin
         axw(FRA_OFS_FP_CONTROL_STATUS_REGISTER, fc[k]);
         pev(3'h0, 6'h08, {ex[k], ex[k], 5'h0});
      end
      axw(FRA_OFS_FP_CONTROL_STATUS_REGISTER, 32'h0);
      pev(3'h0, 6'h04, 7'h50);
      chk("arg", o_exc_arg, 32'h0000_5a5a);
      pev(3'h0, 6'h02, 7'h49);
      pev(3'h0, 6'h02, 7'h45);
      fra_pipe_model_i.ev(3'h0, 7'h43);
      #1 chk("null_break", {o_debug_mode_break, o_nullified, o_kill_delay_slot}, 3'h3);
      axr(FRA_OFS_STATUS, 32'h1, FRA_RESP_OKAY);
      axw(FRA_OFS_STATUS, 32'h1);
      axr(FRA_OFS_STATUS, 32'h0, FRA_RESP_OKAY);
      axr(8'h0c, 32'h0, FRA_RESP_SLVERR);
      finish_test;
   end
   // the whole sequence needs well under a thousand cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles > 5000) begin
         num_errors++;
         finish_test;
      end
   end
endmodule
